//--- logic/bank_consts.svh
// Timing counts and the reset mode-register address for the bank state tracker.
// Assumes a 125 MHz clock; times are in ns and cycles derive from them.
`ifndef BANK_CONSTS_SVH
`define BANK_CONSTS_SVH
`define NUM_BANKS        8
`define CLK_PERIOD_NS    8
`define T_RP_NS          18
`define T_RCD_NS         18
`define T_RFCPB_NS       60
`define T_RFCAB_NS       130
`define T_MRR_NS         16
`define T_MRW_NS         40
`define T_RRD_NS         10
`define T_XP_NS          8
`define T_BURST_NS       32
`define RP_CYC    ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RCD_CYC   ((`T_RCD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFCPB_CYC ((`T_RFCPB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFCAB_CYC ((`T_RFCAB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MRR_CYC   ((`T_MRR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MRW_CYC   ((`T_MRW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RRD_CYC   ((`T_RRD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define XP_CYC    ((`T_XP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BURST_CYC ((`T_BURST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_MR_ADDR    8'h3F
`endif

//--- logic/bank_pkg.sv
// Types shared by the controller end and the memory end.
// Assumes bank_consts.svh is on the include path.
`include "bank_consts.svh"
package bank_pkg;
   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_REFPB,
      CMD_REFAB, CMD_MRR, CMD_MRW, CMD_BST
   } cmd_t;
   typedef enum logic [3:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING,
      BK_RD_AP, BK_WR_AP, BK_PRECHARGING, BK_REFRESHING
   } bank_state_t;
   typedef enum logic [2:0] {
      DEV_NORMAL, DEV_REFRESH_ALL, DEV_MR_READ, DEV_MR_WRITE,
      DEV_PRECHARGE_ALL, DEV_RESETTING, DEV_RESET_MR_READ
   } dev_state_t;
   typedef logic [2:0] bank_t;
   typedef logic [7:0] cnt_t;
   typedef logic [7:0] mr_addr_t;
endpackage

//--- logic/sdram_cmd_if.sv
// Command link between a memory controller and the bank state tracker.
// Both ends share clk; the testbench drives clk and rst.
interface sdram_cmd_if (input wire logic clk);
   logic                cke;
   bank_pkg::cmd_t      cmd;
   bank_pkg::bank_t     bank;
   logic                auto_precharge;
   bank_pkg::mr_addr_t  mr_addr;
   modport controller (output cke, cmd, bank, auto_precharge, mr_addr);
   modport device (input cke, cmd, bank, auto_precharge, mr_addr);
endinterface

//--- logic/sdram_bank_state.sv
// Memory end: per-bank state and timers plus a device-wide state.
// Assumes the controller keeps its own command-spacing duties.
// Functional notes
// - Commands act only with clock enable high twice
// - Idle only after precharge period elapses
// - Active after activate delay, no burst
// - Read or write state until burst ends
// - Busy bank gets only no-operation commands
// - Precharge starts precharging, idle after period
// - Activate starts activating, active after delay
// - Auto-precharge burst busy until precharge completes
// - Device-wide busy states take only no-ops
// - Refreshes return banks idle after cycle time
// - Mode read restores prior state after time
// - Mode write busy, then idle after time
// - Per-bank refresh only to idle bank
// - Refresh-all and mode write need all banks idle
// - Reset comes as a mode write
// - Precharge-all needs every bank precharge-ready
// - Auto-precharge burst bank gets no-ops only
// - Write after read needs finish or stop
// - Read after write needs finish or stop
// - Burst stop ends most recent burst
// - Precharge on idle bank still waits
// - Mode read lets pending bank transitions resolve
// - Activates to different banks spaced apart
module sdram_bank_state (
   input  wire logic                clk,
   input  wire logic                rst,
   sdram_cmd_if.device              link,
   output      bank_pkg::bank_state_t bank_state [`NUM_BANKS],
   output      bank_pkg::dev_state_t  dev_state,
   output      logic                all_idle,
   output      logic                burst_active,
   output      logic                cmd_taken
);
   typedef struct packed {
      bank_pkg::bank_state_t [`NUM_BANKS-1:0] st;
      bank_pkg::cnt_t        [`NUM_BANKS-1:0] cnt;
      bank_pkg::dev_state_t                   dev;
      bank_pkg::cnt_t                         dev_cnt;
      logic                                   cke_prev;
      logic                                   burst_on;
      bank_pkg::bank_t                        burst_bank;
      bank_pkg::cnt_t                         burst_cnt;
      bank_pkg::dev_state_t                   mr_ret;
      logic                                   taken;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   function automatic logic is_idle(input state_t s);
      logic r;
      r = 1'b1;
      for (int i = 0; i < `NUM_BANKS; i++) begin
         if (s.st[i] != bank_pkg::BK_IDLE) begin
            r = 1'b0;
         end
      end
      return r;
   endfunction

   always_comb begin
      logic                 go;
      int unsigned          b;
      nxt_cur = cur_ff;
      go = cur_ff.cke_prev && link.cke;
      b = 32'(link.bank);
      nxt_cur.cke_prev = link.cke;
      nxt_cur.taken = 1'b0;
      // Per-bank timers; precharge-type waits end in idle.
      for (int i = 0; i < `NUM_BANKS; i++) begin
         if (cur_ff.cnt[i] > 8'h00) begin
            nxt_cur.cnt[i] = cur_ff.cnt[i] - 8'h01;
         end
         if (cur_ff.cnt[i] == 8'h01) begin
            case (cur_ff.st[i])
               bank_pkg::BK_ACTIVATING:  nxt_cur.st[i] = bank_pkg::BK_ACTIVE;
               bank_pkg::BK_PRECHARGING,
               bank_pkg::BK_RD_AP,
               bank_pkg::BK_WR_AP,
               bank_pkg::BK_REFRESHING:  nxt_cur.st[i] = bank_pkg::BK_IDLE;
               default:                  nxt_cur.st[i] = cur_ff.st[i];
            endcase
         end
      end
      // Burst length timer ends a non-auto-precharge burst.
      if (cur_ff.burst_on) begin
         nxt_cur.burst_cnt = cur_ff.burst_cnt - 8'h01;
         if (cur_ff.burst_cnt == 8'h01) begin
            nxt_cur.burst_on = 1'b0;
            if (cur_ff.st[cur_ff.burst_bank] == bank_pkg::BK_READING ||
                cur_ff.st[cur_ff.burst_bank] == bank_pkg::BK_WRITING) begin
               nxt_cur.st[cur_ff.burst_bank] = bank_pkg::BK_ACTIVE;
            end
         end
      end
      // Device-wide timer; bank timers keep running during a mode read.
      if (cur_ff.dev_cnt > 8'h00) begin
         nxt_cur.dev_cnt = cur_ff.dev_cnt - 8'h01;
         if (cur_ff.dev_cnt == 8'h01) begin
            nxt_cur.dev = cur_ff.mr_ret;
         end
      end
      if (go && cur_ff.dev_cnt == 8'h00 && link.cmd != bank_pkg::CMD_NOP) begin
         nxt_cur.taken = 1'b1;
         // Any command but a mode read ends auto-initialization.
         if (cur_ff.dev == bank_pkg::DEV_RESETTING) begin
            nxt_cur.dev = bank_pkg::DEV_NORMAL;
         end
         case (link.cmd)
            bank_pkg::CMD_ACT: begin
               nxt_cur.st[b] = bank_pkg::BK_ACTIVATING;
               nxt_cur.cnt[b] = 8'(`RCD_CYC);
            end
            bank_pkg::CMD_RD, bank_pkg::CMD_WR: begin
               if (link.auto_precharge) begin
                  nxt_cur.st[b] = (link.cmd == bank_pkg::CMD_RD) ?
                     bank_pkg::BK_RD_AP : bank_pkg::BK_WR_AP;
                  nxt_cur.cnt[b] = 8'(`BURST_CYC + `RP_CYC);
               end else begin
                  nxt_cur.st[b] = (link.cmd == bank_pkg::CMD_RD) ?
                     bank_pkg::BK_READING : bank_pkg::BK_WRITING;
               end
               // A new burst replaces the previous one.
               if (cur_ff.burst_on && cur_ff.burst_bank != link.bank &&
                   (cur_ff.st[cur_ff.burst_bank] == bank_pkg::BK_READING ||
                    cur_ff.st[cur_ff.burst_bank] == bank_pkg::BK_WRITING)) begin
                  nxt_cur.st[cur_ff.burst_bank] = bank_pkg::BK_ACTIVE;
               end
               nxt_cur.burst_on = 1'b1;
               nxt_cur.burst_bank = link.bank;
               nxt_cur.burst_cnt = 8'(`BURST_CYC);
            end
            bank_pkg::CMD_BST: begin
               if (cur_ff.burst_on) begin
                  nxt_cur.burst_on = 1'b0;
                  if (cur_ff.st[cur_ff.burst_bank] == bank_pkg::BK_READING ||
                      cur_ff.st[cur_ff.burst_bank] == bank_pkg::BK_WRITING) begin
                     nxt_cur.st[cur_ff.burst_bank] = bank_pkg::BK_ACTIVE;
                  end
               end
            end
            bank_pkg::CMD_PRE: begin
               nxt_cur.st[b] = bank_pkg::BK_PRECHARGING;
               nxt_cur.cnt[b] = 8'(`RP_CYC);
            end
            bank_pkg::CMD_PREA: begin
               for (int i = 0; i < `NUM_BANKS; i++) begin
                  nxt_cur.st[i] = bank_pkg::BK_PRECHARGING;
                  nxt_cur.cnt[i] = 8'(`RP_CYC);
               end
               nxt_cur.dev = bank_pkg::DEV_PRECHARGE_ALL;
               nxt_cur.dev_cnt = 8'(`RP_CYC);
               nxt_cur.mr_ret = bank_pkg::DEV_NORMAL;
            end
            bank_pkg::CMD_REFPB: begin
               nxt_cur.st[b] = bank_pkg::BK_REFRESHING;
               nxt_cur.cnt[b] = 8'(`RFCPB_CYC);
            end
            bank_pkg::CMD_REFAB: begin
               for (int i = 0; i < `NUM_BANKS; i++) begin
                  nxt_cur.st[i] = bank_pkg::BK_REFRESHING;
                  nxt_cur.cnt[i] = 8'(`RFCAB_CYC);
               end
               nxt_cur.dev = bank_pkg::DEV_REFRESH_ALL;
               nxt_cur.dev_cnt = 8'(`RFCAB_CYC);
               nxt_cur.mr_ret = bank_pkg::DEV_NORMAL;
            end
            bank_pkg::CMD_MRR: begin
               if (cur_ff.dev == bank_pkg::DEV_RESETTING) begin
                  nxt_cur.dev = bank_pkg::DEV_RESET_MR_READ;
               end else begin
                  nxt_cur.dev = bank_pkg::DEV_MR_READ;
               end
               nxt_cur.dev_cnt = 8'(`MRR_CYC);
               nxt_cur.mr_ret = cur_ff.dev;
            end
            bank_pkg::CMD_MRW: begin
               nxt_cur.dev = bank_pkg::DEV_MR_WRITE;
               nxt_cur.dev_cnt = 8'(`MRW_CYC);
               nxt_cur.mr_ret = (link.mr_addr == `RESET_MR_ADDR) ?
                  bank_pkg::DEV_RESETTING : bank_pkg::DEV_NORMAL;
            end
            default: nxt_cur.taken = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   generate
      for (genvar g = 0; g < `NUM_BANKS; g++) begin : g_out
         assign bank_state[g] = cur_ff.st[g];
      end
   endgenerate
   assign dev_state    = cur_ff.dev;
   assign all_idle     = is_idle(cur_ff) && !cur_ff.burst_on;
   assign burst_active = cur_ff.burst_on;
   assign cmd_taken    = cur_ff.taken;
endmodule

//--- logic/sdram_cmd_issuer.sv
// Controller end: issues one user command at a time when it is legal.
// Assumes the memory end tracks bank states with the same timings.
module sdram_cmd_issuer (
   input  wire logic                clk,
   input  wire logic                rst,
   sdram_cmd_if.controller          link,
   input  wire logic                req_valid,
   input  wire bank_pkg::cmd_t      req_cmd,
   input  wire bank_pkg::bank_t     req_bank,
   input  wire logic                req_auto_precharge,
   input  wire bank_pkg::mr_addr_t  req_mr_addr,
   output      logic                req_ready
);
   typedef struct packed {
      bank_pkg::bank_state_t [`NUM_BANKS-1:0] st;
      bank_pkg::cnt_t        [`NUM_BANKS-1:0] cnt;
      bank_pkg::cnt_t                         dev_cnt;
      bank_pkg::cnt_t                         rrd_cnt;
      bank_pkg::cnt_t                         burst_cnt;
      bank_pkg::cnt_t                         xp_cnt;
      logic                                   cke;
      bank_pkg::cmd_t                         cmd;
      bank_pkg::bank_t                        bank;
      logic                                   ap;
      bank_pkg::mr_addr_t                     mr;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;
   logic   ok;
   logic   idle_all;
   logic   prea_ok;

   function automatic logic bank_open(input bank_pkg::bank_state_t s);
      return s == bank_pkg::BK_ACTIVE || s == bank_pkg::BK_READING ||
             s == bank_pkg::BK_WRITING;
   endfunction

   always_comb begin
      idle_all = (cur_ff.burst_cnt == 8'h00);
      prea_ok = (cur_ff.burst_cnt == 8'h00);
      for (int i = 0; i < `NUM_BANKS; i++) begin
         if (cur_ff.st[i] != bank_pkg::BK_IDLE) begin
            idle_all = 1'b0;
         end
         if (cur_ff.st[i] != bank_pkg::BK_IDLE &&
             cur_ff.st[i] != bank_pkg::BK_ACTIVE) begin
            prea_ok = 1'b0;
         end
      end
      ok = 1'b0;
      if (cur_ff.dev_cnt == 8'h00 && cur_ff.xp_cnt == 8'h00) begin
         case (req_cmd)
            bank_pkg::CMD_ACT:   ok = cur_ff.st[req_bank] == bank_pkg::BK_IDLE &&
                                      cur_ff.rrd_cnt == 8'h00;
            bank_pkg::CMD_RD,
            bank_pkg::CMD_WR:    ok = bank_open(cur_ff.st[req_bank]) &&
                                      cur_ff.burst_cnt == 8'h00;
            bank_pkg::CMD_PRE:   ok = cur_ff.st[req_bank] == bank_pkg::BK_IDLE ||
                                      bank_open(cur_ff.st[req_bank]);
            bank_pkg::CMD_PREA:  ok = prea_ok;
            bank_pkg::CMD_REFPB: ok = cur_ff.st[req_bank] == bank_pkg::BK_IDLE &&
                                      cur_ff.burst_cnt == 8'h00;
            bank_pkg::CMD_REFAB,
            bank_pkg::CMD_MRW:   ok = idle_all;
            bank_pkg::CMD_MRR:   ok = cur_ff.burst_cnt == 8'h00;
            bank_pkg::CMD_BST:   ok = cur_ff.burst_cnt != 8'h00;
            default:             ok = 1'b0;
         endcase
      end
      req_ready = ok;
      nxt_cur = cur_ff;
      nxt_cur.cke = 1'b1;
      nxt_cur.cmd = bank_pkg::CMD_NOP;
      if (cur_ff.xp_cnt > 8'h00) nxt_cur.xp_cnt = cur_ff.xp_cnt - 8'h01;
      if (cur_ff.dev_cnt > 8'h00) nxt_cur.dev_cnt = cur_ff.dev_cnt - 8'h01;
      if (cur_ff.rrd_cnt > 8'h00) nxt_cur.rrd_cnt = cur_ff.rrd_cnt - 8'h01;
      if (cur_ff.burst_cnt > 8'h00) nxt_cur.burst_cnt = cur_ff.burst_cnt - 8'h01;
      for (int i = 0; i < `NUM_BANKS; i++) begin
         if (cur_ff.cnt[i] > 8'h00) nxt_cur.cnt[i] = cur_ff.cnt[i] - 8'h01;
         if (cur_ff.cnt[i] == 8'h01) begin
            nxt_cur.st[i] = (cur_ff.st[i] == bank_pkg::BK_ACTIVATING) ?
               bank_pkg::BK_ACTIVE : bank_pkg::BK_IDLE;
         end
         if (cur_ff.burst_cnt == 8'h01 && bank_open(cur_ff.st[i])) begin
            nxt_cur.st[i] = bank_pkg::BK_ACTIVE;
         end
      end
      if (req_valid && ok) begin
         nxt_cur.cmd = req_cmd;
         nxt_cur.bank = req_bank;
         nxt_cur.ap = req_auto_precharge;
         nxt_cur.mr = req_mr_addr;
         case (req_cmd)
            bank_pkg::CMD_ACT: begin
               nxt_cur.st[req_bank] = bank_pkg::BK_ACTIVATING;
               nxt_cur.cnt[req_bank] = 8'(`RCD_CYC + 1);
               nxt_cur.rrd_cnt = 8'(`RRD_CYC + 1);
            end
            bank_pkg::CMD_RD, bank_pkg::CMD_WR: begin
               nxt_cur.burst_cnt = 8'(`BURST_CYC + 1);
               if (req_auto_precharge) begin
                  nxt_cur.st[req_bank] = bank_pkg::BK_RD_AP;
                  nxt_cur.cnt[req_bank] = 8'(`BURST_CYC + `RP_CYC + 1);
               end
            end
            bank_pkg::CMD_BST: nxt_cur.burst_cnt = 8'h00;
            bank_pkg::CMD_PRE: begin
               nxt_cur.st[req_bank] = bank_pkg::BK_PRECHARGING;
               nxt_cur.cnt[req_bank] = 8'(`RP_CYC + 1);
            end
            bank_pkg::CMD_PREA: begin
               for (int i = 0; i < `NUM_BANKS; i++) begin
                  nxt_cur.st[i] = bank_pkg::BK_PRECHARGING;
                  nxt_cur.cnt[i] = 8'(`RP_CYC + 1);
               end
               nxt_cur.dev_cnt = 8'(`RP_CYC + 1);
            end
            bank_pkg::CMD_REFPB: begin
               nxt_cur.st[req_bank] = bank_pkg::BK_REFRESHING;
               nxt_cur.cnt[req_bank] = 8'(`RFCPB_CYC + 1);
            end
            bank_pkg::CMD_REFAB: nxt_cur.dev_cnt = 8'(`RFCAB_CYC + 1);
            bank_pkg::CMD_MRR:   nxt_cur.dev_cnt = 8'(`MRR_CYC + 1);
            bank_pkg::CMD_MRW:   nxt_cur.dev_cnt = 8'(`MRW_CYC + 1);
            default:             nxt_cur.cmd = req_cmd;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_ff <= '0;
         cur_ff.xp_cnt <= 8'(`XP_CYC + 1);
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign link.cke            = cur_ff.cke;
   assign link.cmd            = cur_ff.cmd;
   assign link.bank           = cur_ff.bank;
   assign link.auto_precharge = cur_ff.ap;
   assign link.mr_addr        = cur_ff.mr;
endmodule

//--- tb/sdram_cmd_properties.sv
// Concurrent checks on the command link between the two ends.
// Assumes both ends share clk and the synchronous active-high rst.
`include "bank_consts.svh"
module sdram_cmd_properties (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 cke,
   input wire bank_pkg::cmd_t       cmd,
   input wire bank_pkg::bank_t      bank,
   input wire logic                 auto_precharge,
   input wire bank_pkg::mr_addr_t   mr_addr,
   input wire bank_pkg::dev_state_t dev_state,
   input wire logic                 all_idle,
   input wire logic                 burst_active,
   input wire logic                 cmd_taken
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_cmd_acted;
      (cmd != bank_pkg::CMD_NOP && cke && $past(cke) &&
       dev_state inside {bank_pkg::DEV_NORMAL, bank_pkg::DEV_RESETTING})
      |=> cmd_taken;
   endproperty
   a_cmd_acted: assert property (p_cmd_acted)
      else $error("link command was not acted on");

   property p_cke_gate;
      (cmd != bank_pkg::CMD_NOP && !(cke && $past(cke))) |=> !cmd_taken;
   endproperty
   a_cke_gate: assert property (p_cke_gate)
      else $error("command acted on with clock enable low");

   property p_busy_nop;
      !(dev_state inside {bank_pkg::DEV_NORMAL, bank_pkg::DEV_RESETTING})
      |-> cmd == bank_pkg::CMD_NOP;
   endproperty
   a_busy_nop: assert property (p_busy_nop)
      else $error("command sent during a device-wide busy state");

   property p_mrw_time;
      $rose(dev_state == bank_pkg::DEV_MR_WRITE) |->
         (dev_state == bank_pkg::DEV_MR_WRITE) [*5] ##1
         (dev_state inside {bank_pkg::DEV_NORMAL, bank_pkg::DEV_RESETTING});
   endproperty
   a_mrw_time: assert property (p_mrw_time)
      else $error("mode write busy time wrong");

   property p_refab_time;
      $rose(dev_state == bank_pkg::DEV_REFRESH_ALL) |->
         (dev_state == bank_pkg::DEV_REFRESH_ALL) [*8] ##1
         (dev_state == bank_pkg::DEV_REFRESH_ALL) [*8] ##1
         (dev_state == bank_pkg::DEV_REFRESH_ALL) ##1
         (dev_state == bank_pkg::DEV_NORMAL && all_idle);
   endproperty
   a_refab_time: assert property (p_refab_time)
      else $error("all-bank refresh time wrong");

   property p_mrr_time;
      $rose(dev_state == bank_pkg::DEV_MR_READ) |->
         (dev_state == bank_pkg::DEV_MR_READ) [*2] ##1
         (dev_state == bank_pkg::DEV_NORMAL);
   endproperty
   a_mrr_time: assert property (p_mrr_time)
      else $error("mode read busy time wrong");

   property p_prea_time;
      $rose(dev_state == bank_pkg::DEV_PRECHARGE_ALL) |->
         (dev_state == bank_pkg::DEV_PRECHARGE_ALL) [*3] ##1
         (dev_state == bank_pkg::DEV_NORMAL && all_idle);
   endproperty
   a_prea_time: assert property (p_prea_time)
      else $error("precharge-all time wrong");

   property p_refab_idle;
      cmd inside {bank_pkg::CMD_REFAB, bank_pkg::CMD_MRW} |-> all_idle;
   endproperty
   a_refab_idle: assert property (p_refab_idle)
      else $error("device-wide command with banks not idle");

   property p_bst_ends;
      (burst_active && cmd == bank_pkg::CMD_BST &&
       dev_state == bank_pkg::DEV_NORMAL) |=> ##1 !burst_active;
   endproperty
   a_bst_ends: assert property (p_bst_ends)
      else $error("burst stop did not end the burst");

   property p_act_spacing;
      cmd == bank_pkg::CMD_ACT |=> cmd != bank_pkg::CMD_ACT;
   endproperty
   a_act_spacing: assert property (p_act_spacing)
      else $error("activates spaced too closely");

   property p_reset_mrw;
      (cmd == bank_pkg::CMD_MRW && mr_addr == `RESET_MR_ADDR &&
       dev_state == bank_pkg::DEV_NORMAL)
      |-> ##6 dev_state == bank_pkg::DEV_RESETTING;
   endproperty
   a_reset_mrw: assert property (p_reset_mrw)
      else $error("reset mode write did not enter resetting");

   c_refab: cover property ($rose(dev_state == bank_pkg::DEV_REFRESH_ALL));
   c_reset: cover property ($rose(dev_state == bank_pkg::DEV_RESETTING));
   c_bst:   cover property (burst_active && cmd == bank_pkg::CMD_BST);
   c_mrr:   cover property ($rose(dev_state == bank_pkg::DEV_MR_READ));
endmodule

//--- tb/tb_top.sv
// Testbench joining the command issuer to the bank state tracker.
// Assumes bank_pkg and the link interface are compiled first.
`include "bank_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  req_valid = 1'b0;
   bank_pkg::cmd_t        req_cmd = bank_pkg::CMD_NOP;
   bank_pkg::bank_t       req_bank = 3'h0;
   logic                  req_auto_precharge = 1'b0;
   bank_pkg::mr_addr_t    req_mr_addr = 8'h00;
   logic                  req_ready;
   bank_pkg::bank_state_t bank_state [`NUM_BANKS];
   bank_pkg::dev_state_t  dev_state;
   logic                  all_idle;
   logic                  burst_active;
   logic                  cmd_taken;
   int                    err_count = 0;
   int                    n_tests = 0;

   always #4 clk = ~clk;

   sdram_cmd_if sdram_cmd_if_i (.clk(clk));
   sdram_cmd_issuer sdram_cmd_issuer_i (
      .clk(clk), .rst(rst), .link(sdram_cmd_if_i),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
      .req_auto_precharge(req_auto_precharge), .req_mr_addr(req_mr_addr),
      .req_ready(req_ready));
   sdram_bank_state sdram_bank_state_i (
      .clk(clk), .rst(rst), .link(sdram_cmd_if_i),
      .bank_state(bank_state), .dev_state(dev_state), .all_idle(all_idle),
      .burst_active(burst_active), .cmd_taken(cmd_taken));
   sdram_cmd_properties sdram_cmd_properties_i (
      .clk(clk), .rst(rst), .cke(sdram_cmd_if_i.cke),
      .cmd(sdram_cmd_if_i.cmd), .bank(sdram_cmd_if_i.bank),
      .auto_precharge(sdram_cmd_if_i.auto_precharge),
      .mr_addr(sdram_cmd_if_i.mr_addr), .dev_state(dev_state),
      .all_idle(all_idle), .burst_active(burst_active),
      .cmd_taken(cmd_taken));

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // A negative bank index selects the device-wide state.
   function automatic logic [7:0] state_of(input int b);
      return (b < 0) ? 8'(dev_state) : 8'(bank_state[b]);
   endfunction

   // Offers one request, then returns at the second falling edge after
   // the take, where the tracker has just registered the command.
   task automatic issue(input bank_pkg::cmd_t c, input int b,
                        input logic ap, input logic [7:0] mr);
      int n;
      n = 0;
      req_cmd = c;
      req_bank = 3'(b);
      req_auto_precharge = ap;
      req_mr_addr = mr;
      req_valid = 1'b1;
      #1;
      while (req_ready !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (req_ready !== 1'b1) begin
         err_count++;
         finish_test();
      end else begin
         @(negedge clk);
         req_valid = 1'b0;
         check("link cmd", 8'(sdram_cmd_if_i.cmd), 8'(c));
         @(negedge clk);
         check("cmd_taken", {7'h00, cmd_taken}, 8'h01);
      end
   endtask

   // Busy state for t cycles, counted from registration, then endst.
   task automatic hold(input int b, input logic [7:0] st, input int t,
                       input logic [7:0] endst);
      for (int i = 0; i < t; i++) begin
         check("busy state", state_of(b), st);
         @(negedge clk);
      end
      check("end state", state_of(b), endst);
   endtask

   task automatic wait_state(input int b, input logic [7:0] st);
      int n;
      n = 0;
      while (state_of(b) !== st && n < 40) begin
         @(negedge clk);
         n++;
      end
      check("awaited state", state_of(b), st);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      issue(bank_pkg::CMD_ACT, 2, 1'b0, 8'h00);
      req_cmd = bank_pkg::CMD_ACT;
      #1;
      check("ready on busy bank", {7'h00, req_ready}, 8'h00);
      hold(2, bank_pkg::BK_ACTIVATING, 3, bank_pkg::BK_ACTIVE);
      $display("test activate done");
      issue(bank_pkg::CMD_RD, 2, 1'b0, 8'h00);
      hold(2, bank_pkg::BK_READING, 4, bank_pkg::BK_ACTIVE);
      issue(bank_pkg::CMD_WR, 2, 1'b0, 8'h00);
      check("writing", state_of(2), bank_pkg::BK_WRITING);
      issue(bank_pkg::CMD_BST, 2, 1'b0, 8'h00);
      check("stopped", state_of(2), bank_pkg::BK_ACTIVE);
      check("burst", {7'h00, burst_active}, 8'h00);
      $display("test bursts done");
      issue(bank_pkg::CMD_MRR, 0, 1'b0, 8'h04);
      hold(-1, bank_pkg::DEV_MR_READ, 2, bank_pkg::DEV_NORMAL);
      check("after read", state_of(2), bank_pkg::BK_ACTIVE);
      issue(bank_pkg::CMD_PRE, 2, 1'b0, 8'h00);
      hold(2, bank_pkg::BK_PRECHARGING, 3, bank_pkg::BK_IDLE);
      issue(bank_pkg::CMD_PRE, 5, 1'b0, 8'h00);
      hold(5, bank_pkg::BK_PRECHARGING, 3, bank_pkg::BK_IDLE);
      $display("test precharge done");
      issue(bank_pkg::CMD_ACT, 1, 1'b0, 8'h00);
      wait_state(1, bank_pkg::BK_ACTIVE);
      issue(bank_pkg::CMD_RD, 1, 1'b1, 8'h00);
      check("auto precharge", state_of(1), bank_pkg::BK_RD_AP);
      wait_state(1, bank_pkg::BK_IDLE);
      issue(bank_pkg::CMD_REFPB, 1, 1'b0, 8'h00);
      hold(1, bank_pkg::BK_REFRESHING, 8, bank_pkg::BK_IDLE);
      $display("test bank refresh done");
      issue(bank_pkg::CMD_ACT, 3, 1'b0, 8'h00);
      issue(bank_pkg::CMD_ACT, 4, 1'b0, 8'h00);
      wait_state(4, bank_pkg::BK_ACTIVE);
      issue(bank_pkg::CMD_PREA, 0, 1'b0, 8'h00);
      hold(-1, bank_pkg::DEV_PRECHARGE_ALL, 3, bank_pkg::DEV_NORMAL);
      check("all idle", {7'h00, all_idle}, 8'h01);
      issue(bank_pkg::CMD_REFAB, 0, 1'b0, 8'h00);
      hold(-1, bank_pkg::DEV_REFRESH_ALL, 17, bank_pkg::DEV_NORMAL);
      $display("test device-wide done");
      issue(bank_pkg::CMD_MRW, 0, 1'b0, 8'h01);
      hold(-1, bank_pkg::DEV_MR_WRITE, 5, bank_pkg::DEV_NORMAL);
      issue(bank_pkg::CMD_MRW, 0, 1'b0, `RESET_MR_ADDR);
      hold(-1, bank_pkg::DEV_MR_WRITE, 5, bank_pkg::DEV_RESETTING);
      issue(bank_pkg::CMD_MRR, 0, 1'b0, 8'h00);
      hold(-1, bank_pkg::DEV_RESET_MR_READ, 2,
           bank_pkg::DEV_RESETTING);
      issue(bank_pkg::CMD_ACT, 0, 1'b0, 8'h00);
      check("left reset", state_of(-1), bank_pkg::DEV_NORMAL);
      check("bank 0", state_of(0), bank_pkg::BK_ACTIVATING);
      $display("test mode registers done");
      repeat (4) @(negedge clk);
      finish_test();
   end
endmodule
